// *** rtl/adcsc_pkg.sv ***
// Constants, register map and types for the converter sample and convert control.
// Assumes a single clock domain and an Avalon-MM slave with 32-bit data.
// What this block does
// - With stop-on-first-irq set, the first converter interrupt clears auto-sample-start.
// - With stop-on-first-irq clear, sequences run on and overwrite the previous results.
// - Auto-sample-start restarts sampling after each conversion and sets sample-enable.
// - Without auto-sample-start, sampling starts when software writes one to sample-enable.
// - Manual trigger source: writing zero to sample-enable ends sampling, starts conversion.
// - Other trigger sources: hardware clears sample-enable to end sampling and convert.
// - Sample-enable reads one while acquiring and zero while holding.
// - Done is set when a conversion finishes, cleared when a new one starts.
// - Software clears done by writing zero; a running conversion is unaffected.
// - Set B negative select at bit 31: one is input one, zero low reference.
// - Set B positive select bits 27..24: inputs 0..12, temperature, reference, open.
// - Set A negative select at bit 23: one is input one, zero low reference.
// - Set A positive select bits 19..16 use the same encoding as set B.
package adcsc_pkg;

   // ----------------------------------------------------------------------
   // Register map (word byte addresses).
   // ----------------------------------------------------------------------
   localparam logic [3:0] ADCSC_OFF_CTRL   = 4'h0;
   localparam logic [3:0] ADCSC_OFF_INSEL  = 4'h4;
   localparam logic [3:0] ADCSC_OFF_STATUS = 4'h8;
   localparam logic [3:0] ADCSC_OFF_MASK   = 4'hC;

   // ----------------------------------------------------------------------
   // Control register fields.
   // ----------------------------------------------------------------------
   localparam int ADCSC_BIT_DONE  = 0;
   localparam int ADCSC_BIT_SAMPLE_ENABLE_FLAG  = 1;
   localparam int ADCSC_BIT_AUTO  = 2;
   localparam int ADCSC_BIT_STOP  = 4;
   localparam int ADCSC_TRIG_LO   = 5;
   localparam int ADCSC_TRIG_W    = 3;
   localparam logic [2:0] ADCSC_TRIG_MANUAL = 3'h0;

   // ----------------------------------------------------------------------
   // Input select fields.
   // ----------------------------------------------------------------------
   localparam int ADCSC_BIT_NEGB  = 31;
   localparam int ADCSC_POSB_LO   = 24;
   localparam int ADCSC_BIT_NEGA  = 23;
   localparam int ADCSC_POSA_LO   = 16;
   localparam int ADCSC_SEL_W     = 4;
   localparam logic [3:0] ADCSC_SEL_TEMP = 4'hD;
   localparam logic [3:0] ADCSC_SEL_IREF = 4'hE;
   localparam logic [3:0] ADCSC_SEL_OPEN = 4'hF;

   // ----------------------------------------------------------------------
   // Interrupt status bits and reset values.
   // ----------------------------------------------------------------------
   localparam int ADCSC_EV_DONE   = 0;
   localparam int ADCSC_EV_AUTOSTOP = 1;
   localparam int ADCSC_EV_W      = 2;
   localparam logic [31:0] ADCSC_RST_WORD = 32'h0000_0000;
   localparam logic [7:0]  ADCSC_SAMPLE_CYCLES = 8'h10;
   localparam logic [7:0]  ADCSC_CONV_CYCLES   = 8'h0C;

   typedef enum logic [1:0] {ADCSC_IDLE, ADCSC_SAMPLE, ADCSC_CONVERT} adcsc_state_t;

endpackage

// *** rtl/adcsc_control.sv ***
// Sample and convert control with input multiplexer selection for a SAR converter.
// Assumes one clock; each conversion is timed here as CONV_CYCLES clocks after its start pulse.
`timescale 1ns/100ps
module adcsc_control
   import adcsc_pkg::*;
#(
   parameter logic [7:0] SAMPLE_CYCLES = ADCSC_SAMPLE_CYCLES,
   parameter logic [7:0] CONV_CYCLES   = ADCSC_CONV_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        hwTrigger,
   output logic             sampling,
   output logic             convStart,
   output logic [3:0]       posSelect,
   output logic             negSelect,
   output logic             useSetB,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // State record.
   // ----------------------------------------------------------------------
   typedef struct packed {
      adcsc_state_t           state;
      logic [7:0]             count;
      logic                   stopIrq;
      logic                   autoStart;
      logic [ADCSC_TRIG_W-1:0] trigSrc;
      logic                   done;
      logic                   setB;
      logic                   altInput;
      logic                   negB;
      logic [3:0]             posB;
      logic                   negA;
      logic [3:0]             posA;
      logic [ADCSC_EV_W-1:0]  status;
      logic [ADCSC_EV_W-1:0]  mask;
      logic                   ack;
      logic [31:0]            rdata;
      logic                   conv;
      logic [3:0]             muxPos;
      logic                   muxNeg;
      logic                   irqOut;
   } adcsc_reg_t;

   adcsc_reg_t r;
   adcsc_reg_t next_r;

   // Merges byte-enabled write data into an old word.
   function automatic logic [31:0] adcscMerge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic [31:0] ctrlWord;
   logic [31:0] selWord;
   logic [31:0] wmCtrl;
   logic [31:0] wmSel;
   logic [31:0] wmStat;
   logic [31:0] wmMask;
   logic        acc;
   logic        convEnd;
   logic        sampEnd;

   // Register images as software sees them; unimplemented bits read zero.
   always_comb begin
      ctrlWord = ADCSC_RST_WORD;
      ctrlWord[ADCSC_BIT_DONE] = r.done;
      ctrlWord[ADCSC_BIT_SAMPLE_ENABLE_FLAG] = (r.state == ADCSC_SAMPLE);
      ctrlWord[ADCSC_BIT_AUTO] = r.autoStart;
      ctrlWord[ADCSC_BIT_STOP] = r.stopIrq;
      ctrlWord[ADCSC_TRIG_LO +: ADCSC_TRIG_W] = r.trigSrc;
      selWord = ADCSC_RST_WORD;
      selWord[ADCSC_BIT_NEGB] = r.negB;
      selWord[ADCSC_POSB_LO +: ADCSC_SEL_W] = r.posB;
      selWord[ADCSC_BIT_NEGA] = r.negA;
      selWord[ADCSC_POSA_LO +: ADCSC_SEL_W] = r.posA;
   end

   // A write lands only at the edge where waitrequest is already low, so the
   // master and the slave agree on the one edge that completes the transfer.
   assign acc    = write && r.ack;
   assign wmCtrl = adcscMerge(ctrlWord, writedata, byteenable);
   assign wmSel  = adcscMerge(selWord, writedata, byteenable);
   assign wmStat = adcscMerge(ADCSC_RST_WORD, writedata, byteenable);
   assign wmMask = adcscMerge({30'h0, r.mask}, writedata, byteenable);
   assign convEnd = (r.state == ADCSC_CONVERT) && (r.count == 8'h00);
   assign sampEnd = (r.state == ADCSC_SAMPLE) && (r.trigSrc != ADCSC_TRIG_MANUAL)
                    && (r.count == 8'h00) && hwTrigger;

   // Next-state logic: bus slave, sequencer, multiplexer and interrupts.
   always_comb begin
      next_r = r;
      next_r.ack = (read || write) && !r.ack;
      next_r.conv = 1'b0;
      if (r.count != 8'h00) begin
         next_r.count = r.count - 8'h01;
      end
      // Bus writes update control, select, status and mask fields.
      if (acc && address == ADCSC_OFF_CTRL) begin
         next_r.stopIrq   = wmCtrl[ADCSC_BIT_STOP];
         next_r.autoStart = wmCtrl[ADCSC_BIT_AUTO];
         next_r.trigSrc   = wmCtrl[ADCSC_TRIG_LO +: ADCSC_TRIG_W];
         if (!wmCtrl[ADCSC_BIT_DONE]) begin
            next_r.done = 1'b0;
         end
         if (wmCtrl[ADCSC_BIT_SAMPLE_ENABLE_FLAG] && !r.autoStart && r.state == ADCSC_IDLE) begin
            next_r.state = ADCSC_SAMPLE;
            next_r.count = SAMPLE_CYCLES;
         end else if (!wmCtrl[ADCSC_BIT_SAMPLE_ENABLE_FLAG] && r.state == ADCSC_SAMPLE
                      && r.trigSrc == ADCSC_TRIG_MANUAL) begin
            next_r.state = ADCSC_CONVERT;
            next_r.count = CONV_CYCLES;
            next_r.conv  = 1'b1;
            next_r.done  = 1'b0;
         end
      end else if (acc && address == ADCSC_OFF_INSEL) begin
         next_r.negB = wmSel[ADCSC_BIT_NEGB];
         next_r.posB = wmSel[ADCSC_POSB_LO +: ADCSC_SEL_W];
         next_r.negA = wmSel[ADCSC_BIT_NEGA];
         next_r.posA = wmSel[ADCSC_POSA_LO +: ADCSC_SEL_W];
      end else if (acc && address == ADCSC_OFF_STATUS) begin
         next_r.status = r.status & ~wmStat[ADCSC_EV_W-1:0];
      end else if (acc && address == ADCSC_OFF_MASK) begin
         next_r.mask = wmMask[ADCSC_EV_W-1:0];
      end
      // Hardware trigger ends sampling without software help.
      if (sampEnd) begin
         next_r.state = ADCSC_CONVERT;
         next_r.count = CONV_CYCLES;
         next_r.conv  = 1'b1;
         next_r.done  = 1'b0;
      end
      // Conversion completion; hardware sets win over software clears.
      if (convEnd) begin
         next_r.done = 1'b1;
         next_r.status[ADCSC_EV_DONE] = 1'b1;
         next_r.setB = r.altInput ? !r.setB : r.setB;
         if (r.stopIrq) begin
            next_r.autoStart = 1'b0;
            next_r.status[ADCSC_EV_AUTOSTOP] = 1'b1;
            next_r.state = ADCSC_IDLE;
         end else if (r.autoStart) begin
            next_r.state = ADCSC_SAMPLE;
            next_r.count = SAMPLE_CYCLES;
         end else begin
            next_r.state = ADCSC_IDLE;
         end
      end
      // Bus read data.
      if (read && !r.ack) begin
         if (address == ADCSC_OFF_CTRL) begin
            next_r.rdata = ctrlWord;
         end else if (address == ADCSC_OFF_INSEL) begin
            next_r.rdata = selWord;
         end else if (address == ADCSC_OFF_STATUS) begin
            next_r.rdata = {30'h0, r.status};
         end else if (address == ADCSC_OFF_MASK) begin
            next_r.rdata = {30'h0, r.mask};
         end else begin
            next_r.rdata = ADCSC_RST_WORD;
         end
      end
      // Multiplexer drive follows the active sample set.
      next_r.muxPos = next_r.setB ? next_r.posB : next_r.posA;
      next_r.muxNeg = next_r.setB ? next_r.negB : next_r.negA;
      next_r.irqOut = |(next_r.status & next_r.mask);
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs come straight from the state record.
   always_comb begin
      readdata    = r.rdata;
      waitrequest = !r.ack;
      sampling    = (r.state == ADCSC_SAMPLE);
      convStart   = r.conv;
      posSelect   = r.muxPos;
      negSelect   = r.muxNeg;
      useSetB     = r.setB;
      irq         = r.irqOut;
   end

endmodule

// *** testbench/adcsc_chk.sv ***
// Port checker for the sample and convert control.
// Assumes the bind at the foot of this file.
`timescale 1ns/100ps
module adcsc_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [3:0] address,
   input wire logic       read,
   input wire logic       write,
   input wire logic       waitrequest,
   input wire logic       sampling,
   input wire logic       convStart,
   input wire logic [3:0] posSelect,
   input wire logic       negSelect,
   input wire logic       useSetB
);
   // All checks run on clk and are quiet in reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence holdS; !sampling [*8]; endsequence
   sequence quietS; !convStart [*8]; endsequence
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no bus answer");
   a_bus_single: assert property (!waitrequest |=> waitrequest)
      else $error("long bus answer");
   a_conv_gap: assert property (convStart |=> quietS)
      else $error("early restart");
   a_conv_hold: assert property (convStart |-> holdS)
      else $error("sampling in convert");
   a_sample_enable_flag_end: assert property ($fell(sampling) |-> ##[0:1] convStart)
      else $error("no start at hold");
   a_conv_cause: assert property (convStart |-> $past(sampling) || $past(sampling, 2))
      else $error("start without sampling");
   a_sel_hold: assert property (!(write && !waitrequest && address == 4'h4)
      |=> $stable({posSelect, negSelect})) else $error("select moved");
   a_setb_off: assert property (!useSetB)
      else $error("set B active");
endmodule
bind adcsc_control adcsc_chk adcsc_chk_inst (.clk(clk), .rst(rst), .address(address),
   .read(read), .write(write), .waitrequest(waitrequest), .sampling(sampling),
   .convStart(convStart), .posSelect(posSelect), .negSelect(negSelect), .useSetB(useSetB));

// *** testbench/adcsc_trig_model.sv ***
// Hardware trigger source on the far side of the control.
// Assumes sampling is the acquire flag, seen on clk.
`timescale 1ns/100ps
module adcsc_trig_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sampling,
   input  wire logic [7:0] delay,
   output logic            hwTrigger
);
   logic [7:0] count;
   // Fires after delay cycles of sampling, drops when sampling ends.
   always_ff @(posedge clk or posedge rst) begin
      if (rst || !sampling) begin
         count <= 8'h00;
         hwTrigger <= 1'b0;
      end else begin
         count <= count + 8'h01;
         hwTrigger <= (count >= delay);
      end
   end
endmodule

// *** testbench/tb_adcsc_control.sv ***
// Self-checking bench for the sample and convert control.
// Assumes the design, checker and trigger model compile first.
`timescale 1ns/100ps
module tb_adcsc_control import adcsc_pkg::*; ();
   logic        clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
   logic [3:0]  address = 4'h0, posSelect;
   logic [31:0] writedata = 32'h0, readdata, rd, wd;
   logic [7:0]  delay = 8'h14;
   logic        waitrequest, hwTrigger, sampling, convStart, negSelect, useSetB, irq;
   int          failCount = 0, nChecks = 0, cycles = 0, nConv = 0, n;
   adcsc_control adcsc_control_inst (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .hwTrigger(hwTrigger), .sampling(sampling),
      .convStart(convStart), .posSelect(posSelect), .negSelect(negSelect),
      .useSetB(useSetB), .irq(irq));
   adcsc_trig_model adcsc_trig_model_inst (.clk(clk), .rst(rst), .sampling(sampling),
      .delay(delay), .hwTrigger(hwTrigger));
   // Clock, conversion counter and hang guard.
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (convStart === 1'b1)
         nConv <= nConv + 1;
      if (cycles == 30000) begin
         failCount++;
         giveVerdict();
      end
   end
   function automatic logic [31:0] selExp(input logic [31:0] d);
      return d & 32'h8F8F0000;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bw(input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic br(input logic [3:0] a);
      address <= a;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Reset, selects, manual and automatic runs, stop, interrupts.
   initial begin
      void'($urandom(32'hCD40));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      br(ADCSC_OFF_CTRL);
      chk("ctrl", ADCSC_RST_WORD, rd);
      for (int i = 0; i < 8; i++) begin
         wd = $urandom;
         if (wd[27:24] == ADCSC_SEL_OPEN)
            wd[27:24] = ADCSC_SEL_IREF;
         if (wd[19:16] == ADCSC_SEL_OPEN)
            wd[19:16] = ADCSC_SEL_IREF;
         if (i < 3)
            wd[19:16] = 4'hC + 4'(i);
         bw(ADCSC_OFF_INSEL, wd);
         br(ADCSC_OFF_INSEL);
         chk("select", selExp(wd), rd);
         chk("pos", {28'h0, wd[19:16]}, {28'h0, posSelect});
         chk("neg", {31'h0, wd[23]}, {31'h0, negSelect});
      end
      bw(ADCSC_OFF_CTRL, 32'h2);
      chk("sampling", 32'h1, {31'h0, sampling});
      n = nConv;
      bw(ADCSC_OFF_CTRL, 32'h0);
      bw(ADCSC_OFF_CTRL, 32'h0);
      repeat (16) @(posedge clk);
      chk("starts", 32'(n + 1), 32'(nConv));
      br(ADCSC_OFF_CTRL);
      chk("done", 32'h1, rd & 32'h3);
      bw(ADCSC_OFF_CTRL, 32'h0);
      br(ADCSC_OFF_CTRL);
      chk("done clear", 32'h0, rd & 32'h3);
      delay <= 8'($urandom_range(35, 4));
      bw(ADCSC_OFF_CTRL, 32'h26);
      n = nConv;
      repeat (200) @(posedge clk);
      chk("auto runs", 32'h1, 32'(nConv - n > 2));
      bw(ADCSC_OFF_CTRL, 32'h36);
      repeat (200) @(posedge clk);
      n = nConv;
      repeat (100) @(posedge clk);
      chk("stopped", 32'(n), 32'(nConv));
      br(ADCSC_OFF_CTRL);
      chk("auto bit", 32'h0, rd & 32'h4);
      bw(ADCSC_OFF_MASK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      br(ADCSC_OFF_STATUS);
      chk("status", 32'h3, rd);
      bw(ADCSC_OFF_MASK, 32'h3);
      chk("irq", 32'h1, {31'h0, irq});
      bw(ADCSC_OFF_STATUS, 32'h3);
      br(ADCSC_OFF_STATUS);
      chk("status clr", 32'h0, rd);
      chk("irq clr", 32'h0, {31'h0, irq});
      giveVerdict();
   end
endmodule
